// File: logic/sfrw_top.sv
// Sector FIFO read pointer backup and rewind, and Ultra DMA extra-word tally.
// Functional notes
// - Backup pointer high six bits, reserved bits zero
// - Rewind read pointer to resend timed-out packet
// - Packet acknowledged: copy current pointer to backup
// - Resend: load backup pointer into current pointer
// - Count words received between pause and terminate
// - Tally saturates at fifteen and holds
// - Launch or soft reset clears the tally
// - ATA read: increment pointer, copy into backup
// - ATA-side reads are never rewound
// - Backup pointer low byte in own register
`default_nettype none

module sfrw_top #(
  parameter int unsigned PTR_W  = sfrw_pkg::PTR_W,
  parameter int unsigned WORD_W = sfrw_pkg::WORD_W
) (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_rstn,
  // Sector FIFO read side.
  input  wire logic                        i_usb_read,
  input  wire logic                        i_usb_ack,
  input  wire logic                        i_usb_resend,
  input  wire logic                        i_ata_read,
  output var  logic [PTR_W-1:0]            o_fifo_read_pointer,
  // Strobes from the interface configuration register write.
  input  wire logic                        i_transfer_launch_set,
  input  wire logic                        i_soft_reset_set,
  // Ultra DMA receive word stream.
  input  wire logic                        i_udma_extra_phase,
  input  wire logic                        i_rx_valid,
  input  wire logic [WORD_W-1:0]           i_rx_data,
  output var  logic                        o_rx_ready,
  output var  logic                        o_word_valid,
  output var  logic [WORD_W-1:0]           o_word_data,
  input  wire logic                        i_word_ready,
  // Microcontroller external data read port.
  input  wire logic                        i_xdata_rd,
  input  wire logic [sfrw_pkg::ADDR_W-1:0] i_xdata_addr,
  output var  logic [sfrw_pkg::DATA_W-1:0] o_xdata_rdata,
  output var  logic                        o_xdata_rvalid
);

  typedef struct packed {
    logic [PTR_W-1:0]             fifo_read_pointer;
    logic [PTR_W-1:0]             read_pointer_backup;
    logic [sfrw_pkg::TALLY_W-1:0] extra_word_tally;
    logic [sfrw_pkg::DATA_W-1:0]  rdata;
    logic                         rvalid;
  } sfrw_state_t;

  sfrw_state_t st_ff;
  sfrw_state_t nxt_st;
  logic        rx_take;
  logic        tally_clear;
  logic        rx_extra;

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  function automatic logic [sfrw_pkg::DATA_W-1:0] reg_read(
    input logic [sfrw_pkg::ADDR_W-1:0]  addr,
    input logic [PTR_W-1:0]             bk,
    input logic [sfrw_pkg::TALLY_W-1:0] tally
  );
    logic [sfrw_pkg::DATA_W-1:0] val;
    val = sfrw_pkg::UNMAPPED_RD;
    unique case (addr)
      sfrw_pkg::READ_POINTER_BACKUP_LOW_ADDR: begin
        val = bk[sfrw_pkg::PTR_LO_W-1:0];
      end
      sfrw_pkg::READ_POINTER_BACKUP_HIGH_ADDR: begin
        val = {{(sfrw_pkg::DATA_W-sfrw_pkg::PTR_HI_W){1'b0}},
               bk[PTR_W-1:sfrw_pkg::PTR_LO_W]};
      end
      sfrw_pkg::UDMA_EXTRA_WORD_COUNT_ADDR: begin
        val = {{(sfrw_pkg::DATA_W-sfrw_pkg::TALLY_W){1'b0}}, tally};
      end
      default: begin
        val = sfrw_pkg::UNMAPPED_RD;
      end
    endcase
    return val;
  endfunction

  // ----------------------------------------------------------------
  // Pointer step
  // ----------------------------------------------------------------
  // The pointer wraps at the top of the sector FIFO without a flag; the
  // write side is what keeps the two pointers apart.
  function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] ptr);
    return PTR_W'(ptr + sfrw_pkg::PTR_STEP);
  endfunction

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  // The buffer keeps accepting the trailing words after a pause while the consumer drains;
  // after a one-cycle stall with a word held it refuses for the next cycle, yet none of them is dropped.
  sfrw_skid_buf #(
    .WIDTH       (WORD_W)
  ) u_rx_buf (
    .i_ref_clk   (i_ref_clk),
    .i_rstn      (i_rstn),
    .i_in_valid  (i_rx_valid),
    .i_in_data   (i_rx_data),
    .o_in_ready  (o_rx_ready),
    .o_out_valid (o_word_valid),
    .o_out_data  (o_word_data),
    .i_out_ready (i_word_ready)
  );

  assign rx_take     = i_rx_valid && o_rx_ready;
  assign tally_clear = i_transfer_launch_set || i_soft_reset_set;
  // Only a word the buffer has taken is counted; a refused one comes again.
  assign rx_extra    = i_udma_extra_phase && rx_take;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;

    // Priority: soft reset, then resend, then ATA read, then the USB-side pair.
    // Acknowledge and read may share a cycle, so they are not exclusive.
    if (i_soft_reset_set) begin
      nxt_st.fifo_read_pointer   = sfrw_pkg::PTR_RESET;
      nxt_st.read_pointer_backup = sfrw_pkg::PTR_RESET;
    end else if (i_usb_resend) begin
      // Backup always trails ATA reads, so a rewind never replays them.
      nxt_st.fifo_read_pointer = st_ff.read_pointer_backup;
    end else if (i_ata_read) begin
      nxt_st.fifo_read_pointer   = ptr_next(st_ff.fifo_read_pointer);
      nxt_st.read_pointer_backup = ptr_next(st_ff.fifo_read_pointer);
    end else begin
      if (i_usb_ack) begin
        // The pointer before this cycle's read marks the acknowledged end.
        nxt_st.read_pointer_backup = st_ff.fifo_read_pointer;
      end
      if (i_usb_read) begin
        nxt_st.fifo_read_pointer = ptr_next(st_ff.fifo_read_pointer);
      end
    end

    // A word arriving in the clearing cycle is counted, not lost.
    if (tally_clear) begin
      nxt_st.extra_word_tally = rx_extra ?
                                sfrw_pkg::TALLY_STEP : sfrw_pkg::TALLY_RESET;
    end else if (rx_extra &&
                 (st_ff.extra_word_tally != sfrw_pkg::TALLY_MAX)) begin
      nxt_st.extra_word_tally = st_ff.extra_word_tally + sfrw_pkg::TALLY_STEP;
    end

    nxt_st.rvalid = i_xdata_rd;
    if (i_xdata_rd) begin
      nxt_st.rdata = reg_read(i_xdata_addr, st_ff.read_pointer_backup,
                              st_ff.extra_word_tally);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_ff <= '{fifo_read_pointer: sfrw_pkg::PTR_RESET,
                 read_pointer_backup: sfrw_pkg::PTR_RESET,
                 extra_word_tally: sfrw_pkg::TALLY_RESET,
                 rdata: sfrw_pkg::RDATA_RESET,
                 rvalid: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_fifo_read_pointer = st_ff.fifo_read_pointer;
  assign o_xdata_rdata       = st_ff.rdata;
  assign o_xdata_rvalid      = st_ff.rvalid;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Checks look one cycle after the strobe, at the registered state; a_extra_accepted checks o_rx_ready in the same cycle.
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  a_ack_copies_ptr: assert property (
    i_usb_ack && !i_soft_reset_set && !i_usb_resend && !i_ata_read
    |=> st_ff.read_pointer_backup == $past(st_ff.fifo_read_pointer))
    else $error("backup pointer not loaded on acknowledge");

  a_resend_rewinds: assert property (
    i_usb_resend && !i_soft_reset_set
    |=> o_fifo_read_pointer == $past(st_ff.read_pointer_backup))
    else $error("read pointer not rewound on resend");

  a_ata_step_both: assert property (
    i_ata_read && !i_usb_resend && !i_soft_reset_set
    |=> (o_fifo_read_pointer == PTR_W'($past(o_fifo_read_pointer) + 1))
        && (st_ff.read_pointer_backup == o_fifo_read_pointer))
    else $error("ATA read did not step and back up the pointer");

  a_backup_holds: assert property (
    !i_usb_ack && !i_ata_read && !i_soft_reset_set
    |=> $stable(st_ff.read_pointer_backup))
    else $error("backup pointer changed without cause");

  a_tally_saturates: assert property (
    st_ff.extra_word_tally == sfrw_pkg::TALLY_MAX && !tally_clear
    |=> st_ff.extra_word_tally == sfrw_pkg::TALLY_MAX)
    else $error("extra-word tally left saturation");

  a_tally_clears: assert property (
    tally_clear && !(i_udma_extra_phase && rx_take)
    |=> st_ff.extra_word_tally == sfrw_pkg::TALLY_RESET)
    else $error("extra-word tally not cleared");

  a_tally_counts: assert property (
    i_udma_extra_phase && rx_take && !tally_clear
    && st_ff.extra_word_tally != sfrw_pkg::TALLY_MAX
    |=> st_ff.extra_word_tally == 4'($past(st_ff.extra_word_tally) + 1))
    else $error("extra word not counted");

  a_tally_idle: assert property (
    !(i_udma_extra_phase && rx_take) && !tally_clear
    |=> $stable(st_ff.extra_word_tally))
    else $error("tally moved outside the extra phase");

  a_high_reserved: assert property (
    i_xdata_rd && i_xdata_addr == sfrw_pkg::READ_POINTER_BACKUP_HIGH_ADDR
    |=> o_xdata_rvalid && o_xdata_rdata ==
        {2'b00, $past(st_ff.read_pointer_backup[PTR_W-1:sfrw_pkg::PTR_LO_W])})
    else $error("backup high byte read wrong");

  a_low_byte_read: assert property (
    i_xdata_rd && i_xdata_addr == sfrw_pkg::READ_POINTER_BACKUP_LOW_ADDR
    |=> o_xdata_rdata == $past(st_ff.read_pointer_backup[sfrw_pkg::PTR_LO_W-1:0]))
    else $error("backup low byte read wrong");

  a_extra_accepted: assert property (
    i_udma_extra_phase && i_rx_valid && i_word_ready [*2]
    |-> o_rx_ready)
    else $error("trailing word refused while consumer drains");

  a_ack_read_pair: assert property (
    i_usb_ack && i_usb_read && !i_soft_reset_set && !i_usb_resend && !i_ata_read
    |=> st_ff.read_pointer_backup == $past(o_fifo_read_pointer)
        && o_fifo_read_pointer == PTR_W'($past(o_fifo_read_pointer) + 1))
    else $error("acknowledge with a read lost the packet end");

  a_usb_read_steps: assert property (
    i_usb_read && !i_soft_reset_set && !i_usb_resend && !i_ata_read
    |=> o_fifo_read_pointer == PTR_W'($past(o_fifo_read_pointer) + 1))
    else $error("USB-side read did not step the pointer");

  a_soft_reset_zero: assert property (
    i_soft_reset_set
    |=> o_fifo_read_pointer == sfrw_pkg::PTR_RESET
        && st_ff.read_pointer_backup == sfrw_pkg::PTR_RESET)
    else $error("soft reset left a pointer set");

  a_ata_not_replayed: assert property (
    i_ata_read && !i_usb_resend && !i_soft_reset_set
    ##1 !i_usb_read && !i_ata_read && !i_usb_resend && !i_soft_reset_set
    ##1 i_usb_resend && !i_soft_reset_set
    |=> $stable(o_fifo_read_pointer))
    else $error("resend replayed data taken by the ATA side");

  a_clear_with_word: assert property (
    tally_clear && i_udma_extra_phase && rx_take
    |=> st_ff.extra_word_tally == sfrw_pkg::TALLY_STEP)
    else $error("word taken in the clearing cycle was lost");

  a_tally_read: assert property (
    i_xdata_rd && i_xdata_addr == sfrw_pkg::UDMA_EXTRA_WORD_COUNT_ADDR
    |=> o_xdata_rdata == {4'h0, $past(st_ff.extra_word_tally)})
    else $error("extra-word count read wrong");

  a_unmapped_zero: assert property (
    i_xdata_rd && i_xdata_addr != sfrw_pkg::READ_POINTER_BACKUP_LOW_ADDR
    && i_xdata_addr != sfrw_pkg::READ_POINTER_BACKUP_HIGH_ADDR
    && i_xdata_addr != sfrw_pkg::UDMA_EXTRA_WORD_COUNT_ADDR
    |=> o_xdata_rdata == sfrw_pkg::UNMAPPED_RD)
    else $error("unmapped address returned data");

  a_read_pulse: assert property (
    1'b1 |=> o_xdata_rvalid == $past(i_xdata_rd))
    else $error("read answer not a single pulse");

  a_rdata_holds: assert property (
    !i_xdata_rd |=> $stable(o_xdata_rdata))
    else $error("read data changed without a read");

  // Covers mark the scenarios the bench is meant to reach.
  c_resend_seen: cover property (i_usb_ack ##[1:20] i_usb_resend);
  c_tally_full: cover property (st_ff.extra_word_tally == sfrw_pkg::TALLY_MAX);
  c_buffer_full: cover property (!o_rx_ready && o_word_valid);
  c_three_extra: cover property (st_ff.extra_word_tally == 4'h3 && !i_udma_extra_phase);
  c_ack_and_read: cover property (i_usb_ack && i_usb_read);

endmodule

`default_nettype wire

// File: pkg/sfrw_pkg.sv
// Shared constants and types for the sector FIFO rewind and extra-word count block.
`default_nettype none

package sfrw_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned PTR_W      = 14;
  localparam int unsigned PTR_LO_W   = 8;
  localparam int unsigned PTR_HI_W   = 6;
  localparam int unsigned ADDR_W     = 16;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned TALLY_W    = 4;
  localparam int unsigned WORD_W     = 16;

  // ----------------------------------------------------------------
  // Register map in external data space
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] READ_POINTER_BACKUP_LOW_ADDR  = 16'hf0f1;
  localparam logic [ADDR_W-1:0] READ_POINTER_BACKUP_HIGH_ADDR = 16'hf0f2;
  localparam logic [ADDR_W-1:0] UDMA_EXTRA_WORD_COUNT_ADDR    = 16'hf0f9;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [PTR_W-1:0]   PTR_RESET   = 14'h0000;
  localparam logic [PTR_W-1:0]   PTR_STEP    = 14'h0001;
  localparam logic [TALLY_W-1:0] TALLY_RESET = 4'h0;
  localparam logic [TALLY_W-1:0] TALLY_STEP  = 4'h1;
  localparam logic [TALLY_W-1:0] TALLY_MAX   = 4'hf;
  localparam logic [DATA_W-1:0]  RDATA_RESET = 8'h00;
  localparam logic [DATA_W-1:0]  UNMAPPED_RD = 8'h00;

  // ----------------------------------------------------------------
  // Two-entry buffer occupancy, Gray coded along fill order
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SFRW_BUF_EMPTY = 2'b00,
    SFRW_BUF_ONE   = 2'b01,
    SFRW_BUF_TWO   = 2'b11
  } sfrw_fill_t;

endpackage

`default_nettype wire

// File: logic/sfrw_skid_buf.sv
// Two-entry valid/ready buffer with registered outputs.
`default_nettype none

module sfrw_skid_buf #(
  parameter int unsigned WIDTH = sfrw_pkg::WORD_W
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output var  logic             o_in_ready,
  output var  logic             o_out_valid,
  output var  logic [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);

  typedef struct packed {
    sfrw_pkg::sfrw_fill_t fill;
    logic [WIDTH-1:0]     head;
    logic [WIDTH-1:0]     tail;
    logic                 in_ready;
    logic                 out_valid;
  } sfrw_buf_state_t;

  sfrw_buf_state_t st_ff;
  sfrw_buf_state_t nxt_st;
  logic            push;
  logic            pop;

  assign push = i_in_valid && st_ff.in_ready;
  assign pop  = st_ff.out_valid && i_out_ready;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff.fill)
      sfrw_pkg::SFRW_BUF_EMPTY: begin
        if (push) begin
          nxt_st.head = i_in_data;
          nxt_st.fill = sfrw_pkg::SFRW_BUF_ONE;
        end
      end
      sfrw_pkg::SFRW_BUF_ONE: begin
        if (push && pop) begin
          nxt_st.head = i_in_data;
        end else if (push) begin
          nxt_st.tail = i_in_data;
          nxt_st.fill = sfrw_pkg::SFRW_BUF_TWO;
        end else if (pop) begin
          nxt_st.fill = sfrw_pkg::SFRW_BUF_EMPTY;
        end
      end
      sfrw_pkg::SFRW_BUF_TWO: begin
        // Ready is low here, so only a drain can happen.
        if (pop) begin
          nxt_st.head = st_ff.tail;
          nxt_st.fill = sfrw_pkg::SFRW_BUF_ONE;
        end
      end
      default: begin
        nxt_st.fill = sfrw_pkg::SFRW_BUF_EMPTY;
      end
    endcase
    nxt_st.in_ready  = (nxt_st.fill != sfrw_pkg::SFRW_BUF_TWO);
    nxt_st.out_valid = (nxt_st.fill != sfrw_pkg::SFRW_BUF_EMPTY);
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_ff <= '{fill: sfrw_pkg::SFRW_BUF_EMPTY, head: '0, tail: '0,
                 in_ready: 1'b1, out_valid: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_in_ready  = st_ff.in_ready;
  assign o_out_valid = st_ff.out_valid;
  assign o_out_data  = st_ff.head;

endmodule

`default_nettype wire

// File: tb/sfrw_dev_model.sv
// Behavioural model of the attached drive's receive word source.
`default_nettype none

module sfrw_dev_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rx_ready,
  output var  logic        o_rx_valid,
  output var  logic [15:0] o_rx_data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] seq;
  logic        took;

  initial begin
    o_rx_valid = 1'b0;
    o_rx_data  = 16'hffff;
    seq        = 16'h0000;
  end

  always @(posedge i_ref_clk) begin
    took <= o_rx_valid & i_rx_ready;
  end

  // Each word is held until taken; a released bus shows the inverse, not a stale copy.
  task automatic send_words(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      repeat (gap) @(posedge i_ref_clk);
      @(posedge i_ref_clk);
      #1;
      o_rx_valid = 1'b1;
      o_rx_data  = 16'ha500 + seq;
      do begin
        @(posedge i_ref_clk);
        #1;
      end while (took !== 1'b1);
      seq        = seq + 16'h0001;
      o_rx_valid = 1'b0;
      o_rx_data  = ~o_rx_data;
    end
  endtask
endmodule

`default_nettype wire

// File: tb/sfrw_top_tb.sv
// Self-checking bench for the read pointer rewind and extra-word tally block.
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end

module sfrw_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_ref_clk = 1'b0;
  logic        i_rstn    = 1'b0;
  logic [5:0]  strobes   = 6'h00;
  logic        phase     = 1'b0;
  logic        rx_valid;
  logic [15:0] rx_data;
  logic        rx_ready;
  logic        word_valid;
  logic [15:0] word_data;
  logic        word_ready = 1'b0;
  logic        rd         = 1'b0;
  logic [15:0] addr       = 16'h0000;
  logic [7:0]  rdata;
  logic        rvalid;
  logic [13:0] ptr;
  logic [15:0] got_cnt    = 16'h0000;
  int          failures   = 0;
  int          samples_checked = 0;
  int          cycles     = 0;

  always #50 i_ref_clk = ~i_ref_clk;

  sfrw_top DUT (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_usb_read(strobes[5]), .i_usb_ack(strobes[4]),
    .i_usb_resend(strobes[3]), .i_ata_read(strobes[2]), .o_fifo_read_pointer(ptr),
    .i_transfer_launch_set(strobes[1]), .i_soft_reset_set(strobes[0]),
    .i_udma_extra_phase(phase), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .o_rx_ready(rx_ready), .o_word_valid(word_valid), .o_word_data(word_data),
    .i_word_ready(word_ready), .i_xdata_rd(rd), .i_xdata_addr(addr),
    .o_xdata_rdata(rdata), .o_xdata_rvalid(rvalid)
  );

  sfrw_dev_model DEV (
    .i_ref_clk(i_ref_clk), .i_rx_ready(rx_ready), .o_rx_valid(rx_valid), .o_rx_data(rx_data)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic strb(input logic [5:0] s, input int n);
    @(posedge i_ref_clk);
    #1;
    strobes = s;
    repeat (n) @(posedge i_ref_clk);
    #1;
    strobes = 6'h00;
  endtask

  task automatic chkreg(input logic [15:0] a, input logic [7:0] e);
    @(posedge i_ref_clk);
    #1;
    rd   = 1'b1;
    addr = a;
    @(posedge i_ref_clk);
    #1;
    rd = 1'b0;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
  endtask

  // Sampled at the falling edge, where both handshake halves have settled.
  always @(negedge i_ref_clk) begin
    if (word_valid === 1'b1 && word_ready === 1'b1) begin
      `CHK("word", 16'(16'ha500 + got_cnt), word_data)
      got_cnt <= got_cnt + 16'h0001;
    end
  end

  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge i_ref_clk);
    #1;
    i_rstn = 1'b1;
    chkreg(16'hf0f1, 8'h00);
    chkreg(16'hf0f2, 8'h00);
    chkreg(16'hf0f9, 8'h00);
    chkreg(16'hf0f3, 8'h00);
    `CHK("ptr", 14'h0000, ptr)
    strb(6'h20, 3);
    chkreg(16'hf0f1, 8'h00);
    strb(6'h10, 1);
    chkreg(16'hf0f1, 8'h03);
    strb(6'h20, 2);
    `CHK("ptr", 14'h0005, ptr)
    strb(6'h08, 1);
    `CHK("ptr", 14'h0003, ptr)
    strb(6'h04, 1);
    `CHK("ptr", 14'h0004, ptr)
    strb(6'h08, 1);
    `CHK("ptr", 14'h0004, ptr)
    strb(6'h04, 300);
    `CHK("ptr", 14'h0130, ptr)
    chkreg(16'hf0f2, 8'h01);
    chkreg(16'hf0f1, 8'h30);
    strb(6'h30, 1);
    `CHK("ptr", 14'h0131, ptr)
    chkreg(16'hf0f1, 8'h30);
    $display("test pointers done");
    word_ready = 1'b1;
    DEV.send_words(2, 0);
    chkreg(16'hf0f9, 8'h00);
    phase = 1'b1;
    DEV.send_words(3, 1);
    chkreg(16'hf0f9, 8'h03);
    phase = 1'b0;
    DEV.send_words(1, 0);
    chkreg(16'hf0f9, 8'h03);
    phase = 1'b1;
    DEV.send_words(13, 2);
    chkreg(16'hf0f9, 8'h0f);
    strb(6'h02, 1);
    chkreg(16'hf0f9, 8'h00);
    DEV.send_words(1, 0);
    chkreg(16'hf0f9, 8'h01);
    fork
      DEV.send_words(1, 0);
      strb(6'h02, 1);
    join
    chkreg(16'hf0f9, 8'h01);
    strb(6'h01, 1);
    chkreg(16'hf0f9, 8'h00);
    chkreg(16'hf0f1, 8'h00);
    `CHK("ptr", 14'h0000, ptr)
    $display("test tally done");
    word_ready = 1'b0;
    fork
      DEV.send_words(3, 0);
    join_none
    repeat (6) @(posedge i_ref_clk);
    #1;
    `CHK("rx_ready", 1'b0, rx_ready)
    `CHK("word_valid", 1'b1, word_valid)
    word_ready = 1'b1;
    wait fork;
    repeat (3) @(posedge i_ref_clk);
    #1;
    `CHK("word_valid", 1'b0, word_valid)
    `CHK("words", 16'h0018, got_cnt)
    chkreg(16'hf0f9, 8'h03);
    $display("test buffer done");
    give_verdict();
  end
endmodule

`undef CHK
`default_nettype wire
